// ---- rtl/mbdc_cmd_decode.sv ----
// splits a command word into its fields
`timescale 1ns/1ns
`default_nettype none
`include "mbdc_params.svh"

module mbdc_cmd_decode
  import mbdc_pkg::*;
(
  input  wire logic [15:0]  i_word,
  output var  mbdc_fields_t o_fields
);

  always_comb begin
    o_fields.stop         = i_word[`MBDC_BIT_STOP];
    o_fields.start        = i_word[`MBDC_BIT_START];
    o_fields.jog          = i_word[`MBDC_BIT_JOG];
    o_fields.clear_faults = i_word[`MBDC_BIT_CLEAR];
    o_fields.dir_cmd      = i_word[`MBDC_BIT_DIR_LSB +: 2];
    o_fields.opto1        = i_word[`MBDC_BIT_OPTO1];
    o_fields.opto2        = i_word[`MBDC_BIT_OPTO2];
    o_fields.accel_cmd    = i_word[`MBDC_BIT_ACCEL_LSB +: 2];
    o_fields.decel_cmd    = i_word[`MBDC_BIT_DECEL_LSB +: 2];
    o_fields.fsrc_cmd     = i_word[`MBDC_BIT_FSRC_LSB +: 3];
    o_fields.relay        = i_word[`MBDC_BIT_RELAY];
  end

endmodule // mbdc_cmd_decode

`default_nettype wire

// ---- rtl/mbdc_cmd_regs.sv ----
// command word and speed reference holding registers of the drive
//
// Contract
// - Only read holding, write single and write multiple function codes are served; any other code is answered with exception 1.
// - Command word writes at 8192 act on bits 0..5 and 8..14 only while start source is 5; bits 6, 7 and 15 ignore start source.
// - A read of address 8192 returns the current command word.
// - Bits 0..3 request stop, start, jog and fault clear; zero requests nothing.
// - Bits 5,4: 01 forward, 10 reverse, 00 and 11 no direction command.
// - Newer firmware: bits 6 and 7 drive opto outputs when their select is 20.
// - Newer firmware: bit 15 drives the relay when its select is 20.
// - Bits 9,8: 01 accel rate 1, 10 rate 2, 11 hold, 00 none.
// - Bits 11,10: 01 decel rate 1, 10 rate 2, 11 hold, 00 none.
// - Bits 14..12 pick frequency source; 000 none, 100..111 presets 0..3.
// - Reference writes at 8193 are used only while reference select is 5.
// - The reference is unsigned tenths of a hertz.
// - A read of address 8193 returns the stored reference.
`timescale 1ns/1ns
`default_nettype none
`include "mbdc_params.svh"

module mbdc_cmd_regs
  import mbdc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_req_valid,
  input  wire mbdc_req_t   i_req,
  output var  logic        o_req_ready,
  output var  logic        o_resp_valid,
  output var  mbdc_resp_t  o_resp,
  input  wire logic [7:0]  i_start_source_select,
  input  wire logic [7:0]  i_speed_reference_select,
  input  wire logic [7:0]  i_opto_output_1_select,
  input  wire logic [7:0]  i_opto_output_2_select,
  input  wire logic [7:0]  i_relay_output_select,
  input  wire logic [15:0] i_firmware_revision,
  output var  mbdc_drive_t o_drive,
  output var  logic [15:0] o_speed_ref,
  output var  logic        o_speed_ref_valid
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // 01 picks rate 1, 10 picks rate 2, 11 and 00 keep the current rate
  function automatic logic rate_next(input logic cur, input logic [1:0] cmd);
    logic nxt;
    nxt = cur;
    if (cmd == `MBDC_CODE_ONE) begin
      nxt = 1'b0;
    end else if (cmd == `MBDC_CODE_TWO) begin
      nxt = 1'b1;
    end
    return nxt;
  endfunction

  mbdc_state_t  state_q, state_d;
  logic [15:0]  cmd_q, cmd_d;
  logic [15:0]  ref_q, ref_d;
  mbdc_resp_t   resp_q, resp_d;
  logic         dir_rev_q, dir_rev_d;
  logic         accel_q, accel_d;
  logic         decel_q, decel_d;
  logic [2:0]   fsrc_q, fsrc_d;
  mbdc_drive_t  drive_q, drive_d;
  logic         ref_valid_q, ref_valid_d;
  mbdc_fields_t fields;
  logic         take;
  logic         is_read;
  logic         is_write;
  logic         func_ok;
  logic         addr_cmd;
  logic         addr_ref;
  logic         cmd_wr;
  logic         net_run;
  logic         net_ref;
  logic         newer_fw;

  assign take     = i_req_valid && (state_q == MBDC_ST_IDLE);
  assign is_read  = i_req.func == `MBDC_FC_READ_HOLDING;
  assign is_write = (i_req.func == `MBDC_FC_WRITE_SINGLE) || (i_req.func == `MBDC_FC_WRITE_MULTI);
  assign func_ok  = is_read || is_write;
  assign addr_cmd = i_req.addr == `MBDC_ADDR_COMMAND;
  assign addr_ref = i_req.addr == `MBDC_ADDR_REFERENCE;
  assign cmd_wr   = take && is_write && addr_cmd;
  assign net_run  = i_start_source_select == `MBDC_SEL_NETWORK_PORT;
  assign net_ref  = i_speed_reference_select == `MBDC_SEL_NETWORK_PORT;
  assign newer_fw = i_firmware_revision >= `MBDC_FRN_OUTPUT_BITS;

  // ****************************************************************
  // request handling
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    ref_d   = ref_q;
    resp_d  = resp_q;
    unique case (state_q)
      MBDC_ST_IDLE: begin
        if (i_req_valid) begin
          state_d     = MBDC_ST_ANSWER;
          resp_d.exc  = 1'b0;
          resp_d.code = i_req.func;
          resp_d.data = i_req.data;
          if (!func_ok) begin
            resp_d.exc  = 1'b1;
            resp_d.code = `MBDC_EXC_ILLEGAL_FUNC;
            resp_d.data = 16'h0000;
          end else if (!addr_cmd && !addr_ref) begin
            resp_d.exc  = 1'b1;
            resp_d.code = `MBDC_EXC_ILLEGAL_ADDR;
            resp_d.data = 16'h0000;
          end else if (is_read) begin
            resp_d.data = addr_cmd ? cmd_q : ref_q;
          end else if (addr_cmd) begin
            cmd_d = i_req.data;
          end else begin
            ref_d = i_req.data;
          end
        end
      end
      MBDC_ST_ANSWER: begin
        state_d = MBDC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= MBDC_ST_IDLE;
      cmd_q   <= `MBDC_RST_COMMAND;
      ref_q   <= `MBDC_RST_REFERENCE;
      resp_q  <= '0;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      ref_q   <= ref_d;
      resp_q  <= resp_d;
    end
  end

  assign o_req_ready  = state_q == MBDC_ST_IDLE;
  assign o_resp_valid = state_q == MBDC_ST_ANSWER;
  assign o_resp       = resp_q;

  // ****************************************************************
  // drive command decode
  // ****************************************************************
  mbdc_cmd_decode mbdc_cmd_decode_inst (
    .i_word   (cmd_d),
    .o_fields (fields)
  );

  always_comb begin
    dir_rev_d = dir_rev_q;
    accel_d   = accel_q;
    decel_d   = decel_q;
    fsrc_d    = fsrc_q;
    if (cmd_wr && net_run) begin
      if (fields.dir_cmd == `MBDC_CODE_ONE) begin
        dir_rev_d = 1'b0;
      end else if (fields.dir_cmd == `MBDC_CODE_TWO) begin
        dir_rev_d = 1'b1;
      end
      accel_d = rate_next(accel_q, fields.accel_cmd);
      decel_d = rate_next(decel_q, fields.decel_cmd);
      if (fields.fsrc_cmd != `MBDC_FSRC_NONE) begin
        fsrc_d = fields.fsrc_cmd;
      end
    end
    drive_d.stop         = net_run && fields.stop;
    drive_d.start        = net_run && fields.start;
    drive_d.jog          = net_run && fields.jog;
    drive_d.clear_faults = net_run && fields.clear_faults;
    drive_d.dir_reverse  = dir_rev_d;
    drive_d.accel_rate2  = accel_d;
    drive_d.decel_rate2  = decel_d;
    drive_d.fsrc         = fsrc_d;
    drive_d.opto1        = newer_fw && (i_opto_output_1_select == `MBDC_OUT_SEL_NETWORK) && fields.opto1;
    drive_d.opto2        = newer_fw && (i_opto_output_2_select == `MBDC_OUT_SEL_NETWORK) && fields.opto2;
    drive_d.relay        = newer_fw && (i_relay_output_select == `MBDC_OUT_SEL_NETWORK) && fields.relay;
    ref_valid_d          = net_ref;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      dir_rev_q   <= 1'b0;
      accel_q     <= 1'b0;
      decel_q     <= 1'b0;
      fsrc_q      <= `MBDC_RST_FSRC;
      drive_q     <= '{fsrc: `MBDC_RST_FSRC, default: 1'b0};
      ref_valid_q <= 1'b0;
    end else begin
      dir_rev_q   <= dir_rev_d;
      accel_q     <= accel_d;
      decel_q     <= decel_d;
      fsrc_q      <= fsrc_d;
      drive_q     <= drive_d;
      ref_valid_q <= ref_valid_d;
    end
  end

  assign o_drive           = drive_q;
  assign o_speed_ref       = ref_q;
  assign o_speed_ref_valid = ref_valid_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_bad_func_excepts: assert property (take && !func_ok |=> o_resp_valid && o_resp.exc &&
      o_resp.code == `MBDC_EXC_ILLEGAL_FUNC) else $error("bad function code not refused");
  a_bad_func_keeps: assert property (take && !func_ok |=> $stable(cmd_q) && $stable(ref_q))
    else $error("bad function code changed a register");
  a_legal_answered: assert property (take && func_ok && (addr_cmd || addr_ref) |=>
      o_resp_valid && !o_resp.exc ##1 o_req_ready) else $error("legal request refused");
  a_cmd_write_store: assert property (cmd_wr |=> cmd_q == $past(i_req.data))
    else $error("command word not stored");
  a_cmd_read_back: assert property (take && is_read && addr_cmd |=> o_resp.data == cmd_q)
    else $error("command word read mismatch");
  a_ref_read_back: assert property (take && is_read && addr_ref |=> o_resp.data == ref_q)
    else $error("reference read mismatch");
  a_run_gate: assert property (!$past(net_run) |-> !o_drive.start && !o_drive.stop && !o_drive.jog &&
      !o_drive.clear_faults)
    else $error("run request while start source is not the network");
  a_dir_reverse: assert property (cmd_wr && net_run && i_req.data[5:4] == 2'h2 |=> o_drive.dir_reverse
      ##1 o_drive.dir_reverse || $past(cmd_wr)) else $error("reverse command lost");
  a_dir_no_cmd: assert property (cmd_wr && i_req.data[5:4] == 2'h3 |=> $stable(dir_rev_q))
    else $error("direction changed on no command");
  a_accel_hold: assert property (cmd_wr && i_req.data[9:8] == 2'h3 |=>
      o_drive.accel_rate2 == $past(accel_q)) else $error("accel rate not held");
  a_decel_pick: assert property (cmd_wr && net_run && i_req.data[11:10] == 2'h2 |=> o_drive.decel_rate2)
    else $error("decel rate 2 not selected");
  a_fsrc_hold: assert property (cmd_wr && i_req.data[14:12] == 3'h0 |=> $stable(fsrc_q))
    else $error("frequency source changed on no command");
  a_out_gate: assert property (o_drive.opto1 || o_drive.opto2 || o_drive.relay |-> $past(newer_fw))
    else $error("output bit acted on old firmware");
  a_relay_sel: assert property (o_drive.relay |-> $past(i_relay_output_select) == `MBDC_OUT_SEL_NETWORK)
    else $error("relay driven without network select");
  a_ref_gate: assert property (o_speed_ref_valid |-> $past(net_ref))
    else $error("reference used while select is not the network");

endmodule // mbdc_cmd_regs

`default_nettype wire

// ---- rtl/mbdc_params.svh ----
// constants of the drive command register block
`ifndef MBDC_PARAMS_SVH
`define MBDC_PARAMS_SVH

// function codes and exception codes
`define MBDC_FC_READ_HOLDING   8'h03
`define MBDC_FC_WRITE_SINGLE   8'h06
`define MBDC_FC_WRITE_MULTI    8'h10
`define MBDC_EXC_ILLEGAL_FUNC  8'h01
`define MBDC_EXC_ILLEGAL_ADDR  8'h02

// register addresses (0-based, as seen on the wire)
`define MBDC_ADDR_COMMAND      16'h2000
`define MBDC_ADDR_REFERENCE    16'h2001

// selection values and the firmware revision that enables the output bits
`define MBDC_SEL_NETWORK_PORT  8'h05
`define MBDC_OUT_SEL_NETWORK   8'h14
`define MBDC_FRN_OUTPUT_BITS   16'h0401

// reset values
`define MBDC_RST_COMMAND       16'h0000
`define MBDC_RST_REFERENCE     16'h0000
`define MBDC_RST_FSRC          3'h1

// command word field positions
`define MBDC_BIT_STOP          0
`define MBDC_BIT_START         1
`define MBDC_BIT_JOG           2
`define MBDC_BIT_CLEAR         3
`define MBDC_BIT_DIR_LSB       4
`define MBDC_BIT_OPTO1         6
`define MBDC_BIT_OPTO2         7
`define MBDC_BIT_ACCEL_LSB     8
`define MBDC_BIT_DECEL_LSB     10
`define MBDC_BIT_FSRC_LSB      12
`define MBDC_BIT_RELAY         15

// two-bit field codes and the three-bit no-source code
`define MBDC_CODE_ONE          2'h1
`define MBDC_CODE_TWO          2'h2
`define MBDC_FSRC_NONE         3'h0

`endif

// ---- rtl/mbdc_pkg.sv ----
// types of the drive command register block
package mbdc_pkg;

  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } mbdc_req_t;

  typedef struct packed {
    logic        exc;
    logic [7:0]  code;
    logic [15:0] data;
  } mbdc_resp_t;

  typedef struct packed {
    logic       stop;
    logic       start;
    logic       jog;
    logic       clear_faults;
    logic [1:0] dir_cmd;
    logic       opto1;
    logic       opto2;
    logic [1:0] accel_cmd;
    logic [1:0] decel_cmd;
    logic [2:0] fsrc_cmd;
    logic       relay;
  } mbdc_fields_t;

  typedef enum logic [2:0] {
    MBDC_FSRC_SPEED_REF = 3'h1,
    MBDC_FSRC_INTERNAL  = 3'h2,
    MBDC_FSRC_NETWORK   = 3'h3,
    MBDC_FSRC_PRESET0   = 3'h4,
    MBDC_FSRC_PRESET1   = 3'h5,
    MBDC_FSRC_PRESET2   = 3'h6,
    MBDC_FSRC_PRESET3   = 3'h7
  } mbdc_fsrc_t;

  typedef struct packed {
    logic       stop;
    logic       start;
    logic       jog;
    logic       clear_faults;
    logic       dir_reverse;
    logic       accel_rate2;
    logic       decel_rate2;
    logic [2:0] fsrc;
    logic       opto1;
    logic       opto2;
    logic       relay;
  } mbdc_drive_t;

  typedef enum logic [1:0] {
    MBDC_ST_IDLE   = 2'b01,
    MBDC_ST_ANSWER = 2'b10
  } mbdc_state_t;

endpackage

// ---- testbench/mbdc_master_model.sv ----
// network master model issuing one register request at a time
`timescale 1ns/1ns
`default_nettype none
module mbdc_master_model
  import mbdc_pkg::*;
(
  input  wire logic       i_clock,
  output var  logic       o_req_valid,
  output var  mbdc_req_t  o_req,
  input  wire logic       i_req_ready,
  input  wire logic       i_resp_valid,
  input  wire mbdc_resp_t i_resp
);
  initial begin
    o_req_valid = 1'b0;
    o_req       = '0;
  end
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      output mbdc_resp_t r, output logic ok);
    int n;
    n = 0;
    @(posedge i_clock);
    o_req_valid <= 1'b1;
    o_req       <= '{func: f, addr: a, data: d};
    @(negedge i_clock);
    while (i_req_ready !== 1'b1 && n < 64) begin
      @(negedge i_clock);
      n++;
    end
    @(posedge i_clock);
    o_req_valid <= 1'b0;
    // released request lines show garbage, not the last value
    o_req       <= ~o_req;
    @(negedge i_clock);
    ok = i_resp_valid;
    r  = i_resp;
  endtask
endmodule // mbdc_master_model
`default_nettype wire

// ---- testbench/tb_mbdc_cmd_regs.sv ----
// self-checking bench of the drive command register block
`timescale 1ns/1ns
`default_nettype none
`include "mbdc_params.svh"
module tb_mbdc_cmd_regs
  import mbdc_pkg::*;
;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic        req_valid, req_ready, resp_valid, sref_ok, ok;
  mbdc_req_t   req;
  mbdc_resp_t  resp, r;
  mbdc_drive_t drive;
  logic [15:0] sref, w;
  logic [7:0]  ss = 8'h00, rs = 8'h00, o1s = 8'h00, o2s = 8'h00, rls = 8'h00;
  logic [15:0] fw = 16'h0401;
  logic [15:0] cmd_m = 16'h0000, ref_m = 16'h0000;
  logic        rev_m = 1'b0, acc_m = 1'b0, dec_m = 1'b0;
  logic [2:0]  fs_m = 3'h1;
  logic [3:0]  k;
  int          bad_count = 0;
  int          compares = 0;

  always #4 i_clock = ~i_clock;

  mbdc_cmd_regs mbdc_cmd_regs_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
    .o_resp_valid(resp_valid), .o_resp(resp), .i_start_source_select(ss), .i_speed_reference_select(rs),
    .i_opto_output_1_select(o1s), .i_opto_output_2_select(o2s), .i_relay_output_select(rls),
    .i_firmware_revision(fw), .o_drive(drive), .o_speed_ref(sref), .o_speed_ref_valid(sref_ok));

  mbdc_master_model mbdc_master_model_inst (
    .i_clock(i_clock), .o_req_valid(req_valid), .o_req(req), .i_req_ready(req_ready),
    .i_resp_valid(resp_valid), .i_resp(resp));

  // ****************************************
  // compare helpers and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic mbdc_drive_t exp_drive();
    mbdc_drive_t d;
    logic run, outs;
    run = (ss == 8'h05);
    outs = (fw >= 16'h0401);
    d = '{stop: run & cmd_m[0], start: run & cmd_m[1], jog: run & cmd_m[2], clear_faults: run & cmd_m[3],
          dir_reverse: rev_m, accel_rate2: acc_m, decel_rate2: dec_m, fsrc: fs_m,
          opto1: outs & (o1s == 8'h14) & cmd_m[6], opto2: outs & (o2s == 8'h14) & cmd_m[7],
          relay: outs & (rls == 8'h14) & cmd_m[15]};
    return d;
  endfunction

  task automatic wr(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    mbdc_master_model_inst.xfer(f, a, d, r, ok);
    chk("write answer", {1'b1, 14'h0, 1'b0, f, d}, {ok, 14'h0, r});
    if (a == 16'h2000) begin
      cmd_m = d;
      if (ss == 8'h05) begin
        if (d[5:4] == 2'h1 || d[5:4] == 2'h2) rev_m = d[5];
        if (d[9:8] == 2'h1 || d[9:8] == 2'h2) acc_m = d[9];
        if (d[11:10] == 2'h1 || d[11:10] == 2'h2) dec_m = d[11];
        if (d[14:12] != 3'h0) fs_m = d[14:12];
      end
    end else begin
      ref_m = d;
    end
    chk("drive", {27'h0, exp_drive()}, {27'h0, drive});
    chk("speed ref", {23'h0, rs == 8'h05, ref_m}, {23'h0, sref_ok, sref});
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    mbdc_master_model_inst.xfer(8'h03, a, 16'h0000, r, ok);
    chk("read answer", {1'b1, 15'h0, 8'h03, e}, {ok, 14'h0, r});
    chk("ready in answer", 40'h0, {39'h0, req_ready});
  endtask

  task automatic bad(input logic [7:0] f, input logic [15:0] a, input logic [7:0] c);
    mbdc_master_model_inst.xfer(f, a, 16'h5a5a, r, ok);
    chk("exception", {1'b1, 14'h0, 1'b1, c, 16'h0}, {ok, 14'h0, r});
  endtask

  task automatic setsel(input logic [7:0] s, input logic [7:0] rf, input logic [7:0] os, input logic [15:0] v);
    @(posedge i_clock);
    ss <= s;
    rs <= rf;
    o1s <= os;
    o2s <= os;
    rls <= os;
    fw <= v;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk("drive after select", {27'h0, exp_drive()}, {27'h0, drive});
  endtask

  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    @(negedge i_clock);
    chk("reset drive", {27'h0, exp_drive()}, {27'h0, drive});
    rd(16'h2000, 16'h0000);
    rd(16'h2001, 16'h0000);
    for (int p = 0; p < 3; p++) begin
      if (p == 0) setsel(8'h05, 8'h05, 8'h14, 16'h0401);
      if (p == 1) setsel(8'h00, 8'h00, 8'h14, 16'h0303);
      if (p == 2) setsel(8'h05, 8'h05, 8'h13, 16'h0401);
      for (int i = 0; i < 8; i++) begin
        k = i[3:0];
        w = {k[2] ^ k[0], k[2:0], k[1:0] + 2'h2, k[1:0] + 2'h1, k[1], ~k[0], k[1:0], k * 4'h3};
        wr(8'h06, 16'h2000, w);
        rd(16'h2000, w);
      end
    end
    setsel(8'h05, 8'h05, 8'h14, 16'h0401);
    wr(8'h06, 16'h2001, 16'h021f);
    rd(16'h2001, 16'h021f);
    wr(8'h10, 16'h2000, 16'h80c2);
    wr(8'h10, 16'h2001, 16'h0064);
    setsel(8'h05, 8'h00, 8'h14, 16'h0401);
    wr(8'h06, 16'h2001, 16'h03e7);
    bad(8'h01, 16'h2000, 8'h01);
    bad(8'h04, 16'h2001, 8'h01);
    bad(8'h0f, 16'h2000, 8'h01);
    bad(8'h17, 16'h2001, 8'h01);
    bad(8'h03, 16'h2002, 8'h02);
    bad(8'h06, 16'h1fff, 8'h02);
    rd(16'h2000, 16'h80c2);
    rd(16'h2001, 16'h03e7);
    give_verdict();
  end
endmodule // tb_mbdc_cmd_regs
`default_nettype wire
